// ---- src/sad_pkg.sv ----
package sad_pkg;

  localparam int WIN_COUNT = 33;

  // window indices into the select vector
  localparam int W_FLASH = 0;
  localparam int W_SYSMEM = 1;
  localparam int W_UID = 2;
  localparam int W_OPTION = 3;
  localparam int W_FACTORY = 4;
  localparam int W_SRAM = 5;
  localparam int W_DMA = 6;
  localparam int W_CLOCK_RESET = 7;
  localparam int W_EXT_IRQ = 8;
  localparam int W_FLASH_CTRL = 9;
  localparam int W_CRC = 10;
  localparam int W_PORT_A = 11;
  localparam int W_PORT_B = 12;
  localparam int W_PORT_F = 13;
  localparam int W_TIMER3 = 14;
  localparam int W_RTC = 15;
  localparam int W_WWDG = 16;
  localparam int W_IWDG = 17;
  localparam int W_UART2 = 18;
  localparam int W_I2C = 19;
  localparam int W_POWER = 20;
  localparam int W_LPTIM = 21;
  localparam int W_SYSCFG = 22;
  localparam int W_COMP = 23;
  localparam int W_ADC = 24;
  localparam int W_TIMER1 = 25;
  localparam int W_SPI1 = 26;
  localparam int W_UART1 = 27;
  localparam int W_TIMER16 = 28;
  localparam int W_TIMER17 = 29;
  localparam int W_DEBUG = 30;
  localparam int W_CORE_PRIVATE = 31;
  localparam int W_TIMER14 = 32;

  localparam logic [31:0] WIN_BASE [WIN_COUNT] = '{
    32'h0800_0000, 32'h1fff_0000, 32'h1fff_0e00, 32'h1fff_0e80, 32'h1fff_0f00,
    32'h2000_0000, 32'h4002_0000, 32'h4002_1000, 32'h4002_1800, 32'h4002_2000,
    32'h4002_3000, 32'h5000_0000, 32'h5000_0400, 32'h5000_1400, 32'h4000_0400,
    32'h4000_2800, 32'h4000_2c00, 32'h4000_3000, 32'h4000_4400, 32'h4000_5400,
    32'h4000_7000, 32'h4000_7c00, 32'h4001_0000, 32'h4001_0200, 32'h4001_2400,
    32'h4001_2c00, 32'h4001_3000, 32'h4001_3800, 32'h4001_4400, 32'h4001_4800,
    32'h4001_5800, 32'he000_0000, 32'h4000_2000};

  // last byte or last register word of each window; compared on word address
  localparam logic [31:0] WIN_LAST [WIN_COUNT] = '{
    32'h0800_ffff, 32'h1fff_0dff, 32'h1fff_0e7f, 32'h1fff_0eff, 32'h1fff_0f7f,
    32'h2000_1fff, 32'h4002_003c, 32'h4002_1060, 32'h4002_1884, 32'h4002_2120,
    32'h4002_3008, 32'h5000_03ff, 32'h5000_07ff, 32'h5000_17ff, 32'h4000_044c,
    32'h4000_282c, 32'h4000_2c08, 32'h4000_3010, 32'h4000_4418, 32'h4000_5430,
    32'h4000_7014, 32'h4000_7c24, 32'h4001_01ff, 32'h4001_021f, 32'h4001_2708,
    32'h4001_2c4c, 32'h4001_300c, 32'h4001_3818, 32'h4001_444c, 32'h4001_484c,
    32'h4001_587f, 32'he00f_ffff, 32'h4000_2050};

  // accepted widths: bit0 byte, bit1 halfword, bit2 word
  localparam logic [2:0] WIDTH_ALL = 3'h7;
  localparam logic [2:0] WIDTH_HALF_WORD = 3'h6;
  localparam logic [2:0] WIDTH_WORD = 3'h4;

  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  localparam logic [1:0] BOOT_FLASH = 2'h0;
  localparam logic [1:0] BOOT_SYSMEM = 2'h1;
  localparam logic [1:0] BOOT_SRAM = 2'h2;
  localparam logic [1:0] RESET_BOOT = BOOT_FLASH;

  localparam logic [31:0] ALIAS_LAST = 32'h0000_ffff;
  localparam logic [31:0] SRAM_SPACE_LAST = 32'h3fff_ffff;
  localparam logic [31:0] APB_BASE = 32'h4000_0000;
  localparam logic [31:0] APB_LAST = 32'h4001_ffff;
  localparam logic [31:0] AHB_BASE = 32'h4002_0000;
  localparam logic [31:0] AHB_LAST = 32'h4fff_ffff;
  localparam logic [31:0] IOP_BASE = 32'h5000_0000;
  localparam logic [31:0] IOP_LAST = 32'h5fff_ffff;
  localparam int SRAM_BYTES = 8192;

endpackage

// ---- src/sad_decode_if.sv ----
`timescale 1ns/1ps
interface sad_decode_if;
  logic [31:0] addr;
  logic [sad_pkg::WIN_COUNT-1:0] hit;
  modport ctrl (output addr, input hit);
  modport bank (input addr, output hit);
endinterface

// ---- src/sad_window_bank.sv ----
`timescale 1ns/1ps
module sad_window_bank #(
  parameter logic [31:0] SRAM_LAST = 32'h2000_1fff
) (
  sad_decode_if.bank dec
);

  logic [31:0] last;

  // word-address compare: windows whose last entry is a register word still cover its bytes
  always_comb
  begin
    last = 32'h0;
    dec.hit = '0;
    for (int i = 0; i < sad_pkg::WIN_COUNT; i++)
    begin
      last = (i == sad_pkg::W_SRAM) ? SRAM_LAST : sad_pkg::WIN_LAST[i];
      dec.hit[i] = (dec.addr[31:2] >= sad_pkg::WIN_BASE[i][31:2]) &&
                   (dec.addr[31:2] <= last[31:2]);
    end
  end

endmodule

// ---- src/sad_decoder.sv ----
// Operation
// - low 64 KB alias follows boot selection
// - decode 128-byte factory configuration area
// - decode 3.5 KB boot loader memory
// - reserved memory: drop writes, zero, error
// - reserved fast-bus space: zero, hard fault
// - reserved peripheral-bus space: zero, no fault
// - clock/reset, interrupt windows take any width
// - power, RTC windows take word, halfword
`timescale 1ns/1ps
module sad_decoder #(
  parameter int SRAM_BYTES = sad_pkg::SRAM_BYTES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [1:0] boot_mode_pin,
  input wire logic req_valid,
  input wire logic [31:0] req_addr,
  input wire logic req_write,
  input wire logic [1:0] req_size,
  input wire logic [31:0] req_wdata,
  input wire logic [31:0] target_rdata,
  output logic tgt_valid,
  output logic [sad_pkg::WIN_COUNT-1:0] tgt_sel,
  output logic [31:0] tgt_addr,
  output logic tgt_write,
  output logic [1:0] tgt_size,
  output logic [31:0] tgt_wdata,
  output logic resp_valid,
  output logic [31:0] resp_rdata,
  output logic resp_error,
  output logic resp_hardfault,
  output logic [1:0] boot_sel
);

  localparam logic [31:0] SRAM_LAST =
    sad_pkg::WIN_BASE[sad_pkg::W_SRAM] + 32'(SRAM_BYTES) - 32'h1;

  sad_decode_if dec ();

  sad_window_bank #(
    .SRAM_LAST(SRAM_LAST)
  ) u_bank (
    .dec(dec)
  );

  logic [1:0] boot_s1;
  logic [1:0] boot_s2;
  logic [1:0] boot_s3;
  logic [2:0] boot_fill;
  logic boot_taken;
  logic [31:0] eff_addr;
  logic [2:0] size_bit;
  logic [sad_pkg::WIN_COUNT-1:0] width_ok;
  logic any_hit;
  logic fits;
  logic in_apb;
  logic in_ahb;
  logic in_iop;
  logic next_err;
  logic next_fault;
  logic s1_valid;
  logic s1_err;
  logic s1_fault;

  // strap pins cross in from outside: three stages, taken once two agree after reset
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      boot_s1 <= sad_pkg::RESET_BOOT;
      boot_s2 <= sad_pkg::RESET_BOOT;
      boot_s3 <= sad_pkg::RESET_BOOT;
      boot_fill <= 3'h0;
    end
    else
    begin
      // fill bits mark stages that hold pin samples; reset values must never be taken as a strap
      boot_fill <= {boot_fill[1:0], 1'b1};
      boot_s1 <= boot_mode_pin;
      boot_s2 <= boot_s1;
      boot_s3 <= boot_s2;
    end
  end

  // selection is frozen once taken until the next reset, so after that capture the alias never moves under the core
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      boot_sel <= sad_pkg::RESET_BOOT;
      boot_taken <= 1'b0;
    end
    else if (!boot_taken && boot_fill[2] && boot_s2 == boot_s3)
    begin
      boot_sel <= boot_s3;
      boot_taken <= 1'b1;
    end
  end

  // alias is rewritten to the real area, then decoded like any other address
  always_comb
  begin
    eff_addr = req_addr;
    if (req_addr <= sad_pkg::ALIAS_LAST)
    begin
      unique case (boot_sel)
        sad_pkg::BOOT_SYSMEM: eff_addr = sad_pkg::WIN_BASE[sad_pkg::W_SYSMEM] |
                                         {16'h0, req_addr[15:0]};
        sad_pkg::BOOT_SRAM: eff_addr = sad_pkg::WIN_BASE[sad_pkg::W_SRAM] |
                                       {16'h0, req_addr[15:0]};
        default: eff_addr = sad_pkg::WIN_BASE[sad_pkg::W_FLASH] |
                            {16'h0, req_addr[15:0]};
      endcase
    end
  end

  assign dec.addr = eff_addr;

  always_comb
  begin
    unique case (req_size)
      sad_pkg::SIZE_BYTE: size_bit = 3'h1;
      sad_pkg::SIZE_HALF: size_bit = 3'h2;
      sad_pkg::SIZE_WORD: size_bit = 3'h4;
      default: size_bit = 3'h0;
    endcase
  end

  // narrow access to a word-only window is answered as an error, never forwarded
  always_comb
  begin
    width_ok = '0;
    for (int i = 0; i < sad_pkg::WIN_COUNT; i++)
    begin
      if (i == sad_pkg::W_CLOCK_RESET || i == sad_pkg::W_EXT_IRQ || i <= sad_pkg::W_SRAM)
        width_ok[i] = |(size_bit & sad_pkg::WIDTH_ALL);
      else if (i == sad_pkg::W_POWER || i == sad_pkg::W_RTC)
        width_ok[i] = |(size_bit & sad_pkg::WIDTH_HALF_WORD);
      else
        width_ok[i] = |(size_bit & sad_pkg::WIDTH_WORD);
    end
  end

  assign any_hit = |dec.hit;
  assign fits = |(dec.hit & width_ok);
  assign in_apb = eff_addr >= sad_pkg::APB_BASE && eff_addr <= sad_pkg::APB_LAST;
  assign in_ahb = eff_addr >= sad_pkg::AHB_BASE && eff_addr <= sad_pkg::AHB_LAST;
  assign in_iop = eff_addr >= sad_pkg::IOP_BASE && eff_addr <= sad_pkg::IOP_LAST;

  always_comb
  begin
    next_fault = !any_hit && (in_ahb || in_iop);
    next_err = (!any_hit && !in_apb && !in_ahb && !in_iop) || (any_hit && !fits);
  end

  // stage one: select and forward; reserved writes never reach a target
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      tgt_valid <= 1'b0;
      tgt_sel <= '0;
      tgt_addr <= 32'h0;
      tgt_write <= 1'b0;
      tgt_size <= sad_pkg::SIZE_WORD;
      tgt_wdata <= 32'h0;
      s1_valid <= 1'b0;
      s1_err <= 1'b0;
      s1_fault <= 1'b0;
    end
    else
    begin
      tgt_valid <= req_valid && fits;
      tgt_sel <= (req_valid && fits) ? dec.hit : '0;
      tgt_addr <= eff_addr;
      tgt_write <= req_valid && fits && req_write;
      tgt_size <= req_size;
      tgt_wdata <= req_wdata;
      s1_valid <= req_valid;
      s1_err <= req_valid && next_err;
      s1_fault <= req_valid && next_fault;
    end
  end

  // stage two: answer; anything not forwarded reads as zero
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      resp_valid <= 1'b0;
      resp_rdata <= 32'h0;
      resp_error <= 1'b0;
      resp_hardfault <= 1'b0;
    end
    else
    begin
      resp_valid <= s1_valid;
      resp_rdata <= (tgt_valid && !tgt_write) ? target_rdata : 32'h0;
      resp_error <= s1_err;
      resp_hardfault <= s1_fault;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence dropped_s;
    !tgt_valid && tgt_sel == '0;
  endsequence

  sequence zero_error_s;
    resp_valid && resp_error && !resp_hardfault && resp_rdata == 32'h0;
  endsequence

  sequence zero_fault_s;
    resp_valid && resp_hardfault && resp_rdata == 32'h0;
  endsequence

  sequence zero_quiet_s;
    resp_valid && !resp_hardfault && !resp_error && resp_rdata == 32'h0;
  endsequence

  sram_select_a: assert property (
    req_valid && req_addr >= 32'h2000_0000 && req_addr <= SRAM_LAST &&
    req_size == sad_pkg::SIZE_WORD |=> tgt_valid && tgt_sel[sad_pkg::W_SRAM] ##1 !resp_error)
    else $error("sram access not selected");

  alias_flash_a: assert property (
    req_valid && req_addr <= 32'h0000_ffff && boot_sel == sad_pkg::BOOT_FLASH &&
    req_size == sad_pkg::SIZE_WORD |=>
    tgt_sel[sad_pkg::W_FLASH] && tgt_addr == (32'h0800_0000 | $past(req_addr)))
    else $error("alias did not reach main flash");

  factory_select_a: assert property (
    req_valid && req_addr >= 32'h1fff_0f00 && req_addr <= 32'h1fff_0f7f |->
    ##1 tgt_sel[sad_pkg::W_FACTORY] == ($past(req_size) != 2'h3))
    else $error("factory area select wrong");

  sysmem_select_a: assert property (
    req_valid && req_addr >= 32'h1fff_0000 && req_addr <= 32'h1fff_0dff &&
    req_size == sad_pkg::SIZE_BYTE |=> tgt_sel[sad_pkg::W_SYSMEM] && $onehot(tgt_sel))
    else $error("boot loader memory not selected");

  reserved_mem_a: assert property (
    req_valid && req_addr > SRAM_LAST && req_addr <= 32'h3fff_ffff |=>
    dropped_s ##1 zero_error_s)
    else $error("reserved memory not refused");

  ahb_fault_a: assert property (
    req_valid && req_addr >= 32'h4002_3400 && req_addr <= 32'h4fff_ffff |=>
    dropped_s ##1 zero_fault_s)
    else $error("reserved fast-bus access gave no hard fault");

  apb_quiet_a: assert property (
    req_valid && req_addr >= 32'h4001_5c00 && req_addr <= 32'h4001_ffff |=>
    dropped_s ##1 zero_quiet_s)
    else $error("reserved peripheral-bus access misanswered");

  byte_accept_a: assert property (
    req_valid && req_addr >= 32'h4002_1800 && req_addr <= 32'h4002_1887 &&
    req_size == sad_pkg::SIZE_BYTE |=>
    tgt_valid && tgt_sel[sad_pkg::W_EXT_IRQ] && tgt_size == sad_pkg::SIZE_BYTE)
    else $error("byte access to interrupt window refused");

  half_only_a: assert property (
    req_valid && req_addr[31:4] == 28'h4000700 && req_size == sad_pkg::SIZE_BYTE |=>
    dropped_s ##1 zero_error_s)
    else $error("byte access to power window accepted");

  port_bounds_a: assert property (
    req_valid && req_addr >= 32'h5000_0800 && req_addr <= 32'h5000_13ff |=>
    dropped_s ##1 zero_fault_s)
    else $error("gap between port windows decoded");

  onehot_sel_a: assert property (
    $onehot0(tgt_sel) && (tgt_valid == (tgt_sel != '0)))
    else $error("select vector not one-hot");

endmodule

// ---- tb/sad_target_model.sv ----
`timescale 1ns/1ps
module sad_target_model (
  input wire logic core_clk,
  input wire logic tgt_valid,
  input wire logic [31:0] tgt_addr,
  output logic [31:0] target_rdata
);
  logic [31:0] noise = 32'h0f0f_0f0f;

  // between transfers the data lines wander, so a stale answer is never mistaken for a fresh one
  always_ff @(posedge core_clk)
  begin
    noise <= {noise[30:0], ~noise[31]};
  end

  always_comb
  begin
    target_rdata = tgt_valid ? (tgt_addr ^ 32'hc3a5_5a3c) : noise;
  end
endmodule

// ---- tb/test_system_address_decoder.sv ----
`timescale 1ns/1ps
module test_system_address_decoder;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] boot_mode_pin = 2'h0;
  logic req_valid = 1'b0;
  logic [31:0] req_addr = 32'h0;
  logic req_write = 1'b0;
  logic [1:0] req_size = 2'h2;
  logic [31:0] req_wdata = 32'h0;
  logic [31:0] target_rdata;
  logic tgt_valid;
  logic [sad_pkg::WIN_COUNT-1:0] tgt_sel;
  logic [31:0] tgt_addr;
  logic tgt_write;
  logic [1:0] tgt_size;
  logic [31:0] tgt_wdata;
  logic resp_valid;
  logic [31:0] resp_rdata;
  logic resp_error;
  logic resp_hardfault;
  logic [1:0] boot_sel;
  int error_cnt = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h861d561e;
  logic [31:0] abase = 32'h0800_0000;
  logic [31:0] ab [4] = '{32'h0800_0000, 32'h1fff_0000, 32'h2000_0000, 32'h0800_0000};
  int ix [4] = '{0, 1, 5, 0};
  logic [99:0] t_q[$];
  logic [99:0] r_q[$];

  initial
  begin
    forever #50 core_clk = ~core_clk;
  end

  sad_decoder u_sad_decoder (.core_clk(core_clk), .reset(reset), .boot_mode_pin(boot_mode_pin),
    .req_valid(req_valid), .req_addr(req_addr), .req_write(req_write), .req_size(req_size),
    .req_wdata(req_wdata), .target_rdata(target_rdata), .tgt_valid(tgt_valid),
    .tgt_sel(tgt_sel), .tgt_addr(tgt_addr), .tgt_write(tgt_write), .tgt_size(tgt_size),
    .tgt_wdata(tgt_wdata), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
    .resp_error(resp_error), .resp_hardfault(resp_hardfault), .boot_sel(boot_sel));

  sad_target_model u_sad_target_model (.core_clk(core_clk), .tgt_valid(tgt_valid),
    .tgt_addr(tgt_addr), .target_rdata(target_rdata));

  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(string nm, logic [99:0] seen, logic [99:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // f: 0 plain, 1 error, 2 hard fault, 3 silent reserved
  task automatic send(logic [31:0] a, logic [1:0] s, logic w, int idx, int f);
    logic [31:0] eff;
    eff = (a < 32'h0001_0000) ? (abase | a) : a;
    seed = lfsr(seed);
    req_valid = 1'b1;
    req_addr = a;
    req_size = s;
    req_write = w;
    req_wdata = seed;
    if (idx >= 0)
      t_q.push_back({33'h1 << idx, eff, w, s, seed});
    r_q.push_back({66'h0, f == 2, f == 1, (w || idx < 0) ? 32'h0 : eff ^ 32'hc3a5_5a3c});
    @(negedge core_clk);
  endtask

  task automatic idle(int n);
    req_valid = 1'b0;
    repeat (n) @(negedge core_clk);
  endtask

  // each forwarded transfer and each answer is matched against the oldest note
  always @(negedge core_clk)
  begin
    if (tgt_valid === 1'b1)
      check("tgt", {tgt_sel, tgt_addr, tgt_write, tgt_size, tgt_wdata}, t_q.pop_front());
    if (resp_valid === 1'b1)
      check("resp", {66'h0, resp_hardfault, resp_error, resp_rdata}, r_q.pop_front());
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial
  begin
    for (int m = 0; m < 4; m++)
    begin
      boot_mode_pin = m[1:0];
      reset = 1'b1;
      repeat (4) @(negedge core_clk);
      reset = 1'b0;
      idle(6);
      check("boot_sel", {98'h0, boot_sel}, 100'(m));
      abase = ab[m];
      send(32'h0000_0010, 2'h2, 1'b0, ix[m], 0);
      send(32'h0000_fffc, 2'h2, 1'b0, (m == 1 || m == 2) ? -1 : 0, (m == 1 || m == 2) ? 1 : 0);
      idle(4);
      $display("boot mode %0d done", m);
    end
    send(32'h2000_0000, 2'h2, 1'b0, 5, 0);
    send(32'h2000_1fff, 2'h0, 1'b1, 5, 0);
    send(32'h2000_2000, 2'h2, 1'b1, -1, 1);
    send(32'h3fff_fffc, 2'h2, 1'b0, -1, 1);
    send(32'h1fff_0f00, 2'h2, 1'b0, 4, 0);
    send(32'h1fff_0f7f, 2'h0, 1'b0, 4, 0);
    send(32'h1fff_0f80, 2'h2, 1'b0, -1, 1);
    send(32'h1fff_0000, 2'h1, 1'b0, 1, 0);
    send(32'h1fff_0dfc, 2'h2, 1'b0, 1, 0);
    send(32'h1fff_1000, 2'h2, 1'b1, -1, 1);
    send(32'h1fff_0e7c, 2'h2, 1'b0, 2, 0);
    send(32'h0001_0000, 2'h2, 1'b0, -1, 1);
    send(32'h6000_0000, 2'h2, 1'b0, -1, 1);
    send(32'h2000_0000, 2'h3, 1'b0, -1, 1);
    send(32'h4002_0040, 2'h2, 1'b0, -1, 2);
    send(32'h4fff_fffc, 2'h2, 1'b1, -1, 2);
    send(32'h5000_0800, 2'h2, 1'b0, -1, 2);
    send(32'h5000_1800, 2'h2, 1'b1, -1, 2);
    send(32'h4000_0000, 2'h2, 1'b0, -1, 3);
    send(32'h4000_2054, 2'h2, 1'b1, -1, 3);
    for (int s = 0; s < 3; s++)
    begin
      send(32'h4002_1000, s[1:0], 1'b0, 7, 0);
      send(32'h4002_1884, s[1:0], 1'b1, 8, 0);
    end
    for (int s = 1; s < 3; s++)
    begin
      send(32'h4000_7000, s[1:0], 1'b0, 20, 0);
      send(32'h4000_282c, s[1:0], 1'b0, 15, 0);
    end
    send(32'h4000_7014, 2'h0, 1'b0, -1, 1);
    send(32'h4000_2800, 2'h0, 1'b1, -1, 1);
    send(32'h5000_0000, 2'h2, 1'b0, 11, 0);
    send(32'h5000_07fc, 2'h2, 1'b1, 12, 0);
    send(32'h5000_17fc, 2'h2, 1'b0, 13, 0);
    send(32'h4002_003c, 2'h2, 1'b0, 6, 0);
    send(32'h4001_3000, 2'h2, 1'b0, 26, 0);
    send(32'h4001_3000, 2'h0, 1'b0, -1, 1);
    send(32'he000_0000, 2'h2, 1'b0, 31, 0);
    idle(4);
    $display("window table done");
    repeat (24)
    begin
      seed = lfsr(seed);
      send(32'h2000_0000 | {19'h0, seed[12:2], 2'h0}, 2'h2, seed[31], 5, 0);
    end
    idle(4);
    check("pending", 100'(t_q.size() + r_q.size()), 100'h0);
    $display("random sram traffic done");
    report_and_stop();
  end
endmodule
